/* design/pstd_ms_tick.sv */
// Millisecond tick generator for the trip timers.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/1ps
module pstd_ms_tick #(
  parameter int CYC_PER_MS = 100000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);

  localparam int CW = $clog2(CYC_PER_MS);
  localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          tick_ff;
  logic          nxt_tick;

  always_comb begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt  = nxt_tick ? '0 : cnt_ff + CW'(1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

/* design/pstd_ms_timer.sv */
// Millisecond down-counter: load restarts it, running while nonzero.
// Assumes a one-cycle tick every millisecond from the tick generator.
`timescale 1ns/1ps
module pstd_ms_timer #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_ms,
  output logic              running
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_cnt = load_ms;
    end else if (tick && cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign running = (cnt_ff != '0);

endmodule

/* design/pstd_pkg.sv */
// Constants shared by the phase-selective trip decision block.
// Assumes a 100 MHz relay clock and a 32-bit classic Wishbone bus.
package pstd_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam int         MODE_W      = 2;
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_3PH    = 2'h1;
  localparam logic [1:0] MODE_1PH3PH = 2'h2;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 5;
  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_MINP  = 5'h04;
  localparam logic [4:0] OFS_EVOL  = 5'h08;
  localparam logic [4:0] OFS_STATE = 5'h0C;
  localparam logic [4:0] OFS_EVST  = 5'h10;
  localparam logic [4:0] OFS_EVCLR = 5'h14;
  localparam logic [4:0] OFS_EVEN  = 5'h18;

  // State register fields
  localparam int ST_PH_LSB = 0;
  localparam int ST_THREE  = 3;
  localparam int ST_GEN    = 4;
  localparam int ST_MINRUN = 5;
  localparam int ST_EVORUN = 6;

  // Event bits: on edges in [3:0], off edges in [7:4]; order a, b, c, general
  localparam int         EVT_W     = 8;
  localparam int         EV_OFF    = 4;
  localparam logic [7:0] EVEN_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          MS_NS          = 1000000;
  localparam int          CYC_PER_MS_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int          MS_W           = 16;
  localparam logic [15:0] SET_MIN_MS     = 16'h0032; // 50 ms
  localparam logic [15:0] SET_MAX_MS     = 16'hEA60; // 60000 ms
  localparam logic [15:0] MINP_DEF_MS    = 16'h0096; // 150 ms
  localparam logic [15:0] EVOL_DEF_MS    = 16'h03E8; // 1000 ms

  // Keep a written setting inside its legal range
  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    if (v < SET_MIN_MS) begin
      return SET_MIN_MS;
    end
    if (v > SET_MAX_MS) begin
      return SET_MAX_MS;
    end
    return v;
  endfunction

  // Byte-lane merge of a 16-bit field
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wr,
                                          input logic [1:0]  sel);
    return {sel[1] ? wr[15:8] : old[15:8], sel[0] ? wr[7:0] : old[7:0]};
  endfunction

  function automatic logic [1:0] count3(input logic [2:0] v);
    return {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

endpackage

/* design/pstd_top.sv */
// Phase-selective trip decision: turns trip requests into trip outputs.
// Assumes requests are synchronous to clk; registers on classic Wishbone.
//
// How it works
// R1: Mode is off, always three-phase, or single-or-three; off after reset.
// R2: Every trip is held at least the minimum pulse time, 50..60000 ms.
// R3: While the evolving-fault time runs, further faults trip all phases.
// R4: Requests on exactly two phases also trip the third phase.
// R5: Force-all-phases turns a single-phase fault into a three-phase trip.
// R6: Block input suppresses every trip output.
// R7: Sources ask single-phase trips with single request plus one phase.
// R8: Three-phase request trips all phases and sets three-phase output.
// R9: Each phase request drives its phase output, subject to mode.
// R10: General trip comes from request status combined with the mode.
// R11: Outputs per phase, three-phase, and general for any trip.
// R12: On and off changes of phase and general outputs raise events.
// R13: Always-three mode trips all phases; off mode keeps outputs low.
// R14: Single-phase trip starts evolving timer; new trips restart pulse timer.
`timescale 1ns/1ps
module pstd_top
  import pstd_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              block_in,
  input  wire logic              single_phase_request,
  input  wire logic              three_phase_request,
  input  wire logic              phase_a_request,
  input  wire logic              phase_b_request,
  input  wire logic              phase_c_request,
  input  wire logic              force_all_phases,
  output logic                   phase_a_trip_out,
  output logic                   phase_b_trip_out,
  output logic                   phase_c_trip_out,
  output logic                   three_phase_trip_out,
  output logic                   general_trip_out,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [MODE_W-1:0] mode_ff;
  logic [MODE_W-1:0] nxt_mode;
  logic [MS_W-1:0]   minp_ff;
  logic [MS_W-1:0]   nxt_minp;
  logic [MS_W-1:0]   evol_ff;
  logic [MS_W-1:0]   nxt_evol;
  logic [EVT_W-1:0]  even_ff;
  logic [EVT_W-1:0]  nxt_even;
  logic [EVT_W-1:0]  evst_ff;
  logic [EVT_W-1:0]  nxt_evst;
  logic [EVT_W-1:0]  clr_mask;
  logic [EVT_W-1:0]  ev_now;
  logic              ack_ff;
  logic              nxt_ack;
  logic [31:0]       rdat_ff;
  logic [31:0]       nxt_rdat;
  logic              req_new;
  logic              wr_take;
  logic [2:0]        held_ff;
  logic [2:0]        nxt_held;
  logic              gen_ff;
  logic              nxt_gen;
  logic              three_ff;
  logic              nxt_three;
  logic              irq_ff;
  logic              nxt_irq;
  logic [2:0]        req;
  logic [2:0]        dec;
  logic              enabled;
  logic              any_req;
  logic              all3;
  logic              grow;
  logic              min_load;
  logic              evo_load;
  logic              min_run;
  logic              evo_run;
  logic              ms_tick;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  pstd_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (ms_tick)
  );

  // One extra ms covers the partial first tick, so the hold is never short
  pstd_ms_timer #(
    .W (MS_W)
  ) u_min_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (ms_tick),
    .load    (min_load),
    .load_ms (minp_ff + MS_W'(1)),
    .running (min_run)
  );

  pstd_ms_timer #(
    .W (MS_W)
  ) u_evo_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick    (ms_tick),
    .load    (evo_load),
    .load_ms (evol_ff + MS_W'(1)),
    .running (evo_run)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Ack comes one cycle after the request; writes land on the ack edge
  assign req_new = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

  always_comb begin
    nxt_ack  = req_new;
    nxt_rdat = rdat_ff;
    nxt_mode = mode_ff;
    nxt_minp = minp_ff;
    nxt_evol = evol_ff;
    nxt_even = even_ff;
    clr_mask = '0;
    if (req_new) begin
      nxt_rdat = 32'h0000_0000;
      case (wb_adr_i)
        OFS_CTRL: begin
          nxt_rdat[MODE_W-1:0] = mode_ff;
        end
        OFS_MINP: begin
          nxt_rdat[MS_W-1:0] = minp_ff;
        end
        OFS_EVOL: begin
          nxt_rdat[MS_W-1:0] = evol_ff;
        end
        OFS_STATE: begin
          nxt_rdat[ST_PH_LSB+:3] = held_ff;
          nxt_rdat[ST_THREE]     = three_ff;
          nxt_rdat[ST_GEN]       = gen_ff;
          nxt_rdat[ST_MINRUN]    = min_run;
          nxt_rdat[ST_EVORUN]    = evo_run;
        end
        OFS_EVST: begin
          nxt_rdat[EVT_W-1:0] = evst_ff;
        end
        OFS_EVEN: begin
          nxt_rdat[EVT_W-1:0] = even_ff;
        end
        default: begin
          nxt_rdat = 32'h0000_0000;
        end
      endcase
    end
    if (wr_take) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          // The unused fourth code is ignored so the mode stays legal
          if (wb_sel_i[0] && wb_dat_i[MODE_W-1:0] != 2'h3) begin
            nxt_mode = wb_dat_i[MODE_W-1:0]; // R1
          end
        end
        OFS_MINP: begin
          nxt_minp = clamp_ms(merge16(minp_ff, wb_dat_i[15:0], wb_sel_i[1:0])); // R2
        end
        OFS_EVOL: begin
          nxt_evol = clamp_ms(merge16(evol_ff, wb_dat_i[15:0], wb_sel_i[1:0])); // R3
        end
        OFS_EVCLR: begin
          if (wb_sel_i[0]) begin
            clr_mask = wb_dat_i[EVT_W-1:0];
          end
        end
        OFS_EVEN: begin
          if (wb_sel_i[0]) begin
            nxt_even = wb_dat_i[EVT_W-1:0];
          end
        end
        default: begin
          nxt_even = even_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
      mode_ff <= MODE_OFF;
      minp_ff <= MINP_DEF_MS;
      evol_ff <= EVOL_DEF_MS;
      even_ff <= EVEN_RST;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
      mode_ff <= nxt_mode;
      minp_ff <= nxt_minp;
      evol_ff <= nxt_evol;
      even_ff <= nxt_even;
    end
  end

  // ----------------------------------------------------------------
  // Trip decision and hold
  // ----------------------------------------------------------------
  always_comb begin
    req     = {phase_c_request, phase_b_request, phase_a_request};
    enabled = (mode_ff == MODE_3PH) || (mode_ff == MODE_1PH3PH); // R1 R13
    any_req = (|req) | single_phase_request | three_phase_request; // R10
    // A single request naming no phase is unsafe to guess, so trip all
    all3 = three_phase_request                           // R8
         | force_all_phases                              // R5
         | (mode_ff == MODE_3PH)                         // R13
         | (count3(req) >= 2'h2)                         // R4
         // A phase that is already tripping is not a further fault
         | (evo_run & (|(req & ~held_ff)))               // R3
         | (single_phase_request & (req == 3'h0));       // R7
    dec = 3'h0;
    if (enabled && any_req) begin
      dec = all3 ? 3'h7 : req; // R9
    end
    grow     = |(dec & ~held_ff);
    nxt_held = held_ff;
    min_load = 1'b0;
    evo_load = 1'b0;
    if (block_in || !enabled) begin
      nxt_held = 3'h0; // R6 R13
    end else if (grow) begin
      nxt_held = held_ff | dec;
      min_load = 1'b1; // R14
      evo_load = (count3(held_ff | dec) == 2'h1); // R14
    end else if (!min_run) begin
      nxt_held = dec; // R2
    end
    nxt_gen   = |nxt_held; // R11
    nxt_three = &nxt_held; // R8 R11
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    ev_now[EV_OFF-1:0]     = {nxt_gen, nxt_held} & ~{gen_ff, held_ff}; // R12
    ev_now[EVT_W-1:EV_OFF] = ~{nxt_gen, nxt_held} & {gen_ff, held_ff}; // R12
    // A new event beats a clear in the same cycle
    nxt_evst = (evst_ff & ~clr_mask) | ev_now;
    nxt_irq  = |(nxt_evst & nxt_even);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff  <= 3'h0;
      gen_ff   <= 1'b0;
      three_ff <= 1'b0;
      evst_ff  <= '0;
      irq_ff   <= 1'b0;
    end else begin
      held_ff  <= nxt_held;
      gen_ff   <= nxt_gen;
      three_ff <= nxt_three;
      evst_ff  <= nxt_evst;
      irq_ff   <= nxt_irq;
    end
  end

  assign phase_a_trip_out     = held_ff[0];
  assign phase_b_trip_out     = held_ff[1];
  assign phase_c_trip_out     = held_ff[2];
  assign three_phase_trip_out = three_ff;
  assign general_trip_out     = gen_ff;
  assign irq                  = irq_ff;
  assign wb_ack_o             = ack_ff;
  assign wb_dat_o             = rdat_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_live;
    !block_in && enabled;
  endsequence

  sequence s_single_issue;
    s_live ##0 (held_ff == 3'h0) && !all3 && (count3(req) == 2'h1);
  endsequence

  property p_mode_reset;
    $rose(rst_n) |-> (mode_ff == MODE_OFF);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not off after reset"); // R1

  property p_block;
    block_in |=> (held_ff == 3'h0) && !gen_ff && !three_ff;
  endproperty
  a_block: assert property (p_block) else $error("trip output while blocked"); // R6

  property p_off;
    (mode_ff == MODE_OFF) |=> !gen_ff;
  endproperty
  a_off: assert property (p_off) else $error("trip output in off mode"); // R13

  property p_two_phase;
    s_live ##0 (count3(req) == 2'h2) |=> three_ff && (held_ff == 3'h7);
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("third phase not added"); // R4

  property p_force;
    s_live ##0 force_all_phases && (|req) |=> (held_ff == 3'h7);
  endproperty
  a_force: assert property (p_force) else $error("force did not trip all phases"); // R5

  property p_three_req;
    s_live ##0 three_phase_request |=> three_ff && gen_ff;
  endproperty
  a_three_req: assert property (p_three_req) else $error("three-phase request ignored"); // R8

  property p_phase_drive;
    s_live ##0 phase_a_request |=> phase_a_trip_out && gen_ff;
  endproperty
  a_phase_drive: assert property (p_phase_drive) else $error("phase request ignored"); // R9

  property p_min_hold;
    $rose(held_ff[0]) ##1 s_live [*3] |-> held_ff[0] && min_run;
  endproperty
  a_min_hold: assert property (p_min_hold) else $error("trip pulse ended early"); // R2

  property p_evol_start;
    s_single_issue |=> evo_run && (count3(held_ff) == 2'h1);
  endproperty
  a_evol_start: assert property (p_evol_start) else $error("evolving timer not started"); // R14

  property p_evol_all;
    evo_run && enabled ##0 s_live ##0 (|(req & ~held_ff)) |=> (held_ff == 3'h7);
  endproperty
  a_evol_all: assert property (p_evol_all) else $error("evolving fault not three-phase"); // R3

  property p_event_on;
    $rose(gen_ff) |-> evst_ff[3];
  endproperty
  a_event_on: assert property (p_event_on) else $error("general on event missing"); // R12

  property p_general;
    (|held_ff) |-> gen_ff;
  endproperty
  a_general: assert property (p_general) else $error("general trip not set"); // R11

endmodule

/* testbench/pstd_req_model.sv */
// Model of the protection functions that feed the trip decision block.
// Assumes the bench hands it one request pattern at a time on cmd.
`timescale 1ns/1ps
module pstd_req_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] cmd,
  output logic            block_in,
  output logic            single_phase_request,
  output logic            three_phase_request,
  output logic            phase_a_request,
  output logic            phase_b_request,
  output logic            phase_c_request,
  output logic            force_all_phases
);
  // ----------------------------------------------------------------
  // Request lines: cmd is {block, single, three, a, b, c, force}
  // ----------------------------------------------------------------
  logic [6:0] req_ff;
  logic [6:0] nxt_req;

  always_comb begin
    nxt_req = cmd;
    // A source never asks a single-phase trip without naming the phase
    if (cmd[5] && (cmd[3:1] == 3'h0)) begin
      nxt_req[5] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff <= 7'h00;
    end else begin
      req_ff <= nxt_req;
    end
  end

  assign block_in             = req_ff[6];
  assign single_phase_request = req_ff[5];
  assign three_phase_request  = req_ff[4];
  assign phase_a_request      = req_ff[3];
  assign phase_b_request      = req_ff[2];
  assign phase_c_request      = req_ff[1];
  assign force_all_phases     = req_ff[0];
endmodule

/* testbench/pstd_tb_top.sv */
// Self-checking bench for the trip decision block.
// Assumes a 10-cycle millisecond so the shortest timers last 500 cycles.
`timescale 1ns/1ps
module pstd_tb_top;
  import pstd_pkg::*;
  localparam int CPM = 10;

  logic              clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0]        wb_sel_i;
  logic [31:0]       wb_dat_i, wb_dat_o, rd;
  logic [6:0]        cmd;
  logic              blk, s1, s3, ra, rb, rc, frc, ta, tb, tc, t3, tg, irq;
  int                miscompares, total_checks;

  pstd_req_model u_req (.clk(clk), .rst_n(reset_n), .cmd(cmd), .block_in(blk),
    .single_phase_request(s1), .three_phase_request(s3), .phase_a_request(ra),
    .phase_b_request(rb), .phase_c_request(rc), .force_all_phases(frc));

  pstd_top #(.CYC_PER_MS(CPM)) u_dut (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .block_in(blk), .single_phase_request(s1), .three_phase_request(s3),
    .phase_a_request(ra), .phase_b_request(rb), .phase_c_request(rc),
    .force_all_phases(frc), .phase_a_trip_out(ta), .phase_b_trip_out(tb),
    .phase_c_trip_out(tc), .three_phase_trip_out(t3), .general_trip_out(tg), .irq(irq));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_trip(input logic [4:0] exp);
    total_checks++;
    if ({ta, tb, tc, t3, tg} !== exp) begin
      miscompares++;
      $display("MISMATCH trip_abc3g expected %b seen %b", exp, {ta, tb, tc, t3, tg});
    end
  endtask

  // Entered just after a rising edge; holds the request until ack is sampled
  task automatic wb_xfer(input logic we, input logic [4:0] adr, input logic [31:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hF;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) begin
      miscompares++;
      $display("MISMATCH wb_ack expected 1 seen timeout");
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wb_check(input logic [4:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    chk_reg($sformatf("reg_%h", adr), exp, rd);
  endtask

  task automatic apply(input logic [6:0] v);
    cmd <= v;
    repeat (3) @(posedge clk);
  endtask

  task automatic wait_ms(input int n);
    repeat (n * CPM) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #300000;
    miscompares++;
    print_verdict();
  end

  initial begin
    miscompares = 0;
    total_checks = 0;
    reset_n = 1'b0;
    cmd = 7'h00;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    wb_check(OFS_CTRL, 32'h0);
    wb_check(OFS_MINP, {16'h0, MINP_DEF_MS});
    wb_check(OFS_EVOL, {16'h0, EVOL_DEF_MS});
    wb_check(OFS_EVEN, 32'h0);
    wb_check(5'h1C, 32'h0);
    apply(7'h10);
    chk_trip(5'h00);
    apply(7'h00);
    // Settings below the floor land on the 50 ms minimum
    wb_xfer(1'b1, OFS_MINP, 32'h0000_0010);
    wb_check(OFS_MINP, 32'h0000_0032);
    wb_xfer(1'b1, OFS_EVOL, 32'h0000_0032);
    wb_xfer(1'b1, OFS_CTRL, 32'h0000_0003);
    wb_check(OFS_CTRL, 32'h0);
    wb_xfer(1'b1, OFS_CTRL, {30'h0, MODE_1PH3PH});
    wb_check(OFS_CTRL, {30'h0, MODE_1PH3PH});
    wb_xfer(1'b1, OFS_EVEN, 32'h0000_0001);
    // One-cycle single-phase fault must still give a full pulse
    cmd <= 7'h28;
    @(posedge clk);
    apply(7'h00);
    chk_trip(5'b10001);
    chk_reg("irq", 32'h1, {31'h0, irq});
    wait_ms(5);
    chk_trip(5'b10001);
    apply(7'h24);
    chk_trip(5'b11111);
    wb_check(OFS_STATE, 32'h0000_007F);
    apply(7'h00);
    wait_ms(47);
    chk_trip(5'b11111);
    wait_ms(5);
    chk_trip(5'b00000);
    wb_check(OFS_EVST, 32'h0000_00FF);
    wb_xfer(1'b1, OFS_EVCLR, 32'h0000_00FF);
    wb_check(OFS_EVST, 32'h0);
    chk_reg("irq", 32'h0, {31'h0, irq});
    apply(7'h0C);
    chk_trip(5'b11111);
    apply(7'h00);
    wait_ms(55);
    apply(7'h29);
    chk_trip(5'b11111);
    apply(7'h69);
    chk_trip(5'b00000);
    wait_ms(55);
    apply(7'h00);
    chk_trip(5'b00000);
    apply(7'h10);
    chk_trip(5'b11111);
    apply(7'h00);
    wait_ms(55);
    chk_trip(5'b00000);
    // A lasting single-phase fault must stay single-phase
    apply(7'h28);
    wait_ms(2);
    chk_trip(5'b10001);
    apply(7'h00);
    wait_ms(55);
    wb_xfer(1'b1, OFS_CTRL, {30'h0, MODE_3PH});
    apply(7'h28);
    chk_trip(5'b11111);
    chk_reg("irq", 32'h1, {31'h0, irq});
    // Masking the only enabled event must drop the interrupt
    wb_xfer(1'b1, OFS_EVEN, 32'h0);
    chk_reg("irq", 32'h0, {31'h0, irq});
    apply(7'h00);
    wait_ms(55);
    chk_trip(5'b00000);
    print_verdict();
  end
endmodule
